/* rtl/fsp_pkg.sv */
package fsp_pkg;
   // Array geometry
   localparam int          ADDR_W        = 21;
   localparam logic [21:0] ARRAY_BYTES   = 22'h20_0000;
   localparam logic [21:0] BLOCK_BYTES   = 22'h01_0000;
   localparam logic [21:0] SECTOR_BYTES  = 22'h00_1000;
   localparam logic [21:0] SEC_MAX_BYTES = 22'h00_8000;
   localparam logic [20:0] PAGE_MASK     = 21'h00_00FF;
   localparam logic [20:0] SE_MASK       = 21'h00_0FFF;
   localparam logic [20:0] BE32_MASK     = 21'h00_7FFF;
   localparam logic [20:0] BE64_MASK     = 21'h00_FFFF;
   localparam logic [20:0] TOP_ADDR      = 21'h1F_FFFF;

   // Opcodes
   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_WRSR  = 8'h01;
   localparam logic [7:0] OP_PP    = 8'h02;
   localparam logic [7:0] OP_QPP   = 8'h32;
   localparam logic [7:0] OP_SE    = 8'h20;
   localparam logic [7:0] OP_BE32  = 8'h52;
   localparam logic [7:0] OP_BE64  = 8'hD8;
   localparam logic [7:0] OP_CE1   = 8'hC7;
   localparam logic [7:0] OP_CE2   = 8'h60;
   localparam logic [7:0] OP_SUSP  = 8'h75;
   localparam logic [7:0] OP_RESM  = 8'h7A;

   // Frame bit and byte counts
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [2:0] BYTES_OP  = 3'h1;
   localparam logic [2:0] BYTES_SR1 = 3'h2;
   localparam logic [2:0] BYTES_SR2 = 3'h3;
   localparam logic [2:0] BYTES_ADR = 3'h4;
   localparam logic [2:0] BYTES_PGM = 3'h5;
   localparam logic [2:0] BYTES_SAT = 3'h7;

   // Status lock modes
   localparam logic [1:0] LOCK_SW  = 2'h0;
   localparam logic [1:0] LOCK_HW  = 2'h1;
   localparam logic [1:0] LOCK_PWR = 2'h2;

   // Status bit positions
   localparam int SB_BUSY    = 0;
   localparam int SB_WEL     = 1;
   localparam int SB_LVL     = 2;
   localparam int SB_TB      = 5;
   localparam int SB_SEC     = 6;
   localparam int SB_LOCK_LO = 7;
   localparam int SB_LOCK_HI = 8;
   localparam int SB_QE      = 9;
   localparam int SB_SUS     = 15;

   // Pin synchroniser layout
   localparam int NPIN   = 4;
   localparam int PIN_CK = 3;
   localparam int PIN_CS = 2;
   localparam int PIN_DI = 1;
   localparam int PIN_WP = 0;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READOUT} fsp_frame_e;
endpackage

/* rtl/fsp_prot_if.sv */
`timescale 1ns/1ps
interface fsp_prot_if;
   logic [2:0]  level;
   logic        tb;
   logic        sec;
   logic        none;
   logic [20:0] lo;
   logic [20:0] hi;
   modport dec  (input level, tb, sec, output none, lo, hi);
   modport user (output level, tb, sec, input none, lo, hi);
endinterface

/* rtl/fsp_prot_dec.sv */
`timescale 1ns/1ps
module fsp_prot_dec
   import fsp_pkg::*;
(
   fsp_prot_if.dec pif
);
   logic [21:0] size_w;
   logic [21:0] lo_w;
   logic [21:0] hi_w;
   logic [2:0]  sh_w;

   // Protected size from level and granularity
   always_comb begin
      sh_w   = pif.level - 3'h1;
      size_w = '0;
      if (pif.level[2:1] == 2'b11) begin
         size_w = ARRAY_BYTES;
      end else if (pif.sec) begin
         if (pif.level[2]) begin
            size_w = SEC_MAX_BYTES;
         end else if (pif.level != 3'h0) begin
            size_w = SECTOR_BYTES << sh_w;
         end
      end else if (pif.level != 3'h0) begin
         size_w = BLOCK_BYTES << sh_w;
      end
   end

   // Region placed at top or bottom end
   always_comb begin
      lo_w = pif.tb ? '0 : ARRAY_BYTES - size_w;
      hi_w = pif.tb ? size_w - 22'h1 : ARRAY_BYTES - 22'h1;
   end

   assign pif.none = (pif.level == 3'h0);
   assign pif.lo   = lo_w[ADDR_W-1:0];
   assign pif.hi   = hi_w[ADDR_W-1:0];
endmodule

/* rtl/fsp_flash_wp.sv */
`timescale 1ns/1ps
module fsp_flash_wp
   import fsp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        spi_clk_i,
   input  wire logic        cs_n_i,
   input  wire logic        serial_in_pin_i,
   input  wire logic        quad_lane_two_i,
   input  wire logic        arr_done_i,
   input  wire logic [15:0] nv_image_i,
   output logic             serial_out_o,
   output logic             serial_out_oe_n_o,
   output logic             arr_req_o,
   output logic [7:0]       arr_cmd_o,
   output logic [20:0]      arr_addr_o,
   output logic [15:0]      status_o,
   output logic             quad_lane_enable_o
);
   fsp_prot_if pif ();

   logic [NPIN-1:0] pin_raw, meta_ff, sync_ff;
   logic            sclk_d_ff, cs_d_ff;
   fsp_frame_e      state_ff;
   logic [2:0]      bit_ff, byte_ff;
   logic [7:0]      shin_ff, opc_ff, shout_ff, nxt_byte;
   logic [23:0]     addr_ff;
   logic [15:0]     wdat_ff;
   logic [2:0]      lvl_ff;
   logic [1:0]      lock_ff;
   logic            init_ff, tb_ff, sec_ff, qe_ff, sus_ff;
   logic            wel_ff, busy_ff, erasing_ff;
   logic [15:0]     stat_w;
   logic            sclk_rise, sclk_fall, cs_fall, cs_rise, fr_end;
   logic            is_pgm, is_ers, is_ce, hits, wp_high;
   logic            lock_ok, pe_ok, sr_ok, sus_go, res_go;
   logic [20:0]     op_lo, op_hi;

   // Two-flop synchronisers for all pins
   assign pin_raw = {spi_clk_i, cs_n_i, serial_in_pin_i, quad_lane_two_i};
   for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            meta_ff[g] <= 1'b1;
            sync_ff[g] <= 1'b1;
         end else begin
            meta_ff[g] <= pin_raw[g];
            sync_ff[g] <= meta_ff[g];
         end
      end
   end

   // Edge history of clock and select
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sclk_d_ff <= 1'b1;
         cs_d_ff   <= 1'b1;
      end else begin
         sclk_d_ff <= sync_ff[PIN_CK];
         cs_d_ff   <= sync_ff[PIN_CS];
      end
   end

   assign sclk_rise = sync_ff[PIN_CK] & ~sclk_d_ff & ~sync_ff[PIN_CS];
   assign sclk_fall = ~sync_ff[PIN_CK] & sclk_d_ff & ~sync_ff[PIN_CS];
   assign cs_fall   = ~sync_ff[PIN_CS] & cs_d_ff;
   assign cs_rise   = sync_ff[PIN_CS] & ~cs_d_ff;
   assign nxt_byte  = {shin_ff[6:0], sync_ff[PIN_DI]};

   // Frame sequencer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= ST_IDLE;
      end else if (cs_rise) begin
         state_ff <= ST_IDLE;
      end else if (cs_fall) begin
         state_ff <= ST_SHIFT;
      end else if (state_ff == ST_SHIFT && sclk_rise && bit_ff == LAST_BIT
                   && byte_ff == 3'h0
                   && (nxt_byte == OP_RDSR1 || nxt_byte == OP_RDSR2)) begin
         state_ff <= ST_READOUT;
      end
   end

   // Bit and byte counting, byte capture
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_ff  <= '0;
         byte_ff <= '0;
         shin_ff <= '0;
         opc_ff  <= '0;
         addr_ff <= '0;
         wdat_ff <= '0;
      end else if (cs_fall) begin
         bit_ff  <= '0;
         byte_ff <= '0;
      end else if (state_ff != ST_IDLE && sclk_rise) begin
         bit_ff  <= bit_ff + 3'h1;
         shin_ff <= nxt_byte;
         if (bit_ff == LAST_BIT) begin
            if (byte_ff != BYTES_SAT) begin
               byte_ff <= byte_ff + 3'h1;
            end
            unique case (byte_ff)
               3'h0: opc_ff <= nxt_byte;
               3'h1: begin
                  addr_ff[23:16] <= nxt_byte;
                  wdat_ff[7:0]   <= nxt_byte;
               end
               3'h2: begin
                  addr_ff[15:8] <= nxt_byte;
                  wdat_ff[15:8] <= nxt_byte;
               end
               3'h3: addr_ff[7:0] <= nxt_byte;
               default: ;
            endcase
         end
      end
   end

   // Status read shifter, driven after falling clock edges
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shout_ff          <= '0;
         serial_out_o      <= 1'b0;
         serial_out_oe_n_o <= 1'b1;
      end else begin
         serial_out_oe_n_o <= (state_ff != ST_READOUT);
         if (state_ff == ST_SHIFT && sclk_rise && bit_ff == LAST_BIT) begin
            shout_ff <= (nxt_byte == OP_RDSR2) ? stat_w[15:8] : stat_w[7:0];
         end else if (state_ff == ST_READOUT && sclk_fall) begin
            serial_out_o <= shout_ff[7];
            shout_ff     <= {shout_ff[6:0], shout_ff[7]};
         end
      end
   end

   // Operation decode and protection check
   assign is_pgm = (opc_ff == OP_PP) || (opc_ff == OP_QPP);
   assign is_ers = (opc_ff == OP_SE) || (opc_ff == OP_BE32) || (opc_ff == OP_BE64);
   assign is_ce  = (opc_ff == OP_CE1) || (opc_ff == OP_CE2);
   assign fr_end = cs_rise && state_ff == ST_SHIFT
                   && bit_ff == 3'h0 && byte_ff != 3'h0;

   always_comb begin
      op_lo = addr_ff[ADDR_W-1:0] & ~PAGE_MASK;
      op_hi = addr_ff[ADDR_W-1:0] | PAGE_MASK;
      unique case (opc_ff)
         OP_SE: begin
            op_lo = addr_ff[ADDR_W-1:0] & ~SE_MASK;
            op_hi = addr_ff[ADDR_W-1:0] | SE_MASK;
         end
         OP_BE32: begin
            op_lo = addr_ff[ADDR_W-1:0] & ~BE32_MASK;
            op_hi = addr_ff[ADDR_W-1:0] | BE32_MASK;
         end
         OP_BE64: begin
            op_lo = addr_ff[ADDR_W-1:0] & ~BE64_MASK;
            op_hi = addr_ff[ADDR_W-1:0] | BE64_MASK;
         end
         OP_CE1, OP_CE2: begin
            op_lo = '0;
            op_hi = TOP_ADDR;
         end
         default: ;
      endcase
   end

   assign pif.level = lvl_ff;
   assign pif.tb    = tb_ff;
   assign pif.sec   = sec_ff;
   fsp_prot_dec u_dec (
      .pif (pif.dec)
   );

   assign hits    = !pif.none && op_lo <= pif.hi && op_hi >= pif.lo;
   // Quad mode turns the protect pin into a data lane
   assign wp_high = qe_ff | sync_ff[PIN_WP];
   assign lock_ok = (lock_ff == LOCK_SW)
                    || (lock_ff == LOCK_HW && wp_high);
   assign pe_ok   = fr_end && wel_ff && !busy_ff && !hits
                    && ((is_pgm && byte_ff >= BYTES_PGM)
                        || (is_ers && byte_ff == BYTES_ADR)
                        || (is_ce && byte_ff == BYTES_OP));
   assign sr_ok   = fr_end && wel_ff && !busy_ff && lock_ok
                    && opc_ff == OP_WRSR
                    && (byte_ff == BYTES_SR1 || byte_ff == BYTES_SR2);
   assign sus_go  = fr_end && opc_ff == OP_SUSP && byte_ff == BYTES_OP
                    && busy_ff && erasing_ff;
   assign res_go  = fr_end && opc_ff == OP_RESM && byte_ff == BYTES_OP
                    && sus_ff && !busy_ff;

   // Non-volatile fields: image load after reset, then status writes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_ff <= 1'b0;
         lvl_ff  <= '0;
         tb_ff   <= 1'b0;
         sec_ff  <= 1'b0;
         lock_ff <= LOCK_SW;
         qe_ff   <= 1'b0;
      end else if (!init_ff) begin
         init_ff <= 1'b1;
         lvl_ff  <= nv_image_i[SB_LVL +: 3];
         tb_ff   <= nv_image_i[SB_TB];
         sec_ff  <= nv_image_i[SB_SEC];
         qe_ff   <= nv_image_i[SB_QE];
         lock_ff <= ({nv_image_i[SB_LOCK_HI], nv_image_i[SB_LOCK_LO]} == LOCK_PWR)
                    ? LOCK_SW
                    : {nv_image_i[SB_LOCK_HI], nv_image_i[SB_LOCK_LO]};
      end else if (sr_ok) begin
         lvl_ff  <= wdat_ff[SB_LVL +: 3];
         tb_ff   <= wdat_ff[SB_TB];
         sec_ff  <= wdat_ff[SB_SEC];
         lock_ff[0] <= wdat_ff[SB_LOCK_LO];
         if (byte_ff == BYTES_SR2) begin
            lock_ff[1] <= wdat_ff[SB_LOCK_HI];
            qe_ff      <= wdat_ff[SB_QE];
         end
      end
   end

   // Write enable latch
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wel_ff <= 1'b0;
      end else if (fr_end && !busy_ff && opc_ff == OP_WREN && byte_ff == BYTES_OP) begin
         wel_ff <= 1'b1;
      end else if ((fr_end && !busy_ff && opc_ff == OP_WRDI && byte_ff == BYTES_OP)
                   || pe_ok || sr_ok) begin
         wel_ff <= 1'b0;
      end
   end

   // Busy flag, erase tracking and suspend flag
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_ff    <= 1'b0;
         erasing_ff <= 1'b0;
         sus_ff     <= 1'b0;
      end else begin
         if (pe_ok || sr_ok || res_go) begin
            busy_ff <= 1'b1;
         end else if (arr_done_i || sus_go) begin
            busy_ff <= 1'b0;
         end
         if (pe_ok) begin
            erasing_ff <= is_ers | is_ce;
         end
         if (sus_go) begin
            sus_ff <= 1'b1;
         end else if (res_go) begin
            sus_ff <= 1'b0;
         end
      end
   end

   // Array request towards the storage core
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         arr_req_o  <= 1'b0;
         arr_cmd_o  <= '0;
         arr_addr_o <= '0;
      end else begin
         arr_req_o <= pe_ok | sr_ok | sus_go | res_go;
         if (pe_ok || sr_ok || sus_go || res_go) begin
            arr_cmd_o  <= opc_ff;
            arr_addr_o <= op_lo;
         end
      end
   end

   // Live status image
   always_comb begin
      stat_w             = '0;
      stat_w[SB_BUSY]    = busy_ff;
      stat_w[SB_WEL]     = wel_ff;
      stat_w[SB_LVL +: 3] = lvl_ff;
      stat_w[SB_TB]      = tb_ff;
      stat_w[SB_SEC]     = sec_ff;
      stat_w[SB_LOCK_LO] = lock_ff[0];
      stat_w[SB_LOCK_HI] = lock_ff[1];
      stat_w[SB_QE]      = qe_ff;
      stat_w[SB_SUS]     = sus_ff;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_o           <= '0;
         quad_lane_enable_o <= 1'b0;
      end else begin
         status_o           <= stat_w;
         quad_lane_enable_o <= qe_ff;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_PROT_REFUSE: assert property (
      (fr_end && hits && (is_pgm || is_ers || is_ce)) |=> !arr_req_o && !busy_ff)
      else $error("protected program or erase was started");
   AST_TOP_END: assert property (
      (!tb_ff && !pif.none) |-> pif.hi == TOP_ADDR)
      else $error("top region does not end at array top");
   AST_SECTOR4K: assert property (
      (sec_ff && lvl_ff == 3'h1 && tb_ff) |-> pif.lo == '0 && pif.hi == SE_MASK)
      else $error("bottom 4KB sector range wrong");
   AST_BLOCK1M: assert property (
      (!sec_ff && lvl_ff == 3'h5 && !tb_ff) |-> pif.lo == 21'h10_0000)
      else $error("upper half range wrong");
   AST_LOCK_PIN: assert property (
      (fr_end && opc_ff == OP_WRSR && lock_ff == LOCK_HW && !wp_high)
      |=> $stable(lvl_ff) && !arr_req_o && !busy_ff)
      else $error("status write passed a low protect pin");
   AST_LOCK_HARD: assert property (
      (fr_end && opc_ff == OP_WRSR && lock_ff[1]) |=> !arr_req_o ##1 $stable(lock_ff))
      else $error("status write passed a hard lock");
   AST_NEED_WEL: assert property (
      (fr_end && opc_ff == OP_WRSR && !wel_ff) |=> !arr_req_o)
      else $error("status write without enable latch");
   AST_ODD_ABORT: assert property (
      (cs_rise && bit_ff != 3'h0) |=> !arr_req_o)
      else $error("partial byte frame started an operation");
   AST_BUSY_IGNORE: assert property (
      (busy_ff && fr_end && opc_ff == OP_WREN && !arr_done_i) |=> $stable(wel_ff))
      else $error("instruction served while busy");
   AST_WRITE_START: assert property (
      (arr_req_o && arr_cmd_o != OP_SUSP) |-> busy_ff && (arr_cmd_o == OP_RESM || !wel_ff))
      else $error("write operation did not set busy or clear latch");
   AST_SUSPEND: assert property (
      sus_go |=> sus_ff && !busy_ff ##1 status_o[SB_SUS])
      else $error("suspend flag not raised");

   COV_PROGRAM: cover property (pe_ok && is_pgm);
   COV_SR_WRITE: cover property (sr_ok ##1 arr_req_o);
   COV_READOUT: cover property (state_ff == ST_READOUT && sclk_fall);
endmodule

/* verif/fsp_spi_host.sv */
`timescale 1ns/1ps
module fsp_spi_host (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // Idle bus: select high, clock parked low
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // One framed transfer of nbits, MSB first, data line sampled on rise
   task automatic xfer(input logic [63:0] tx, input int nbits, output logic [31:0] rx);
      rx = '0;
      cs_n_o <= 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         mosi_o <= tx[i];
         #80;
         sclk_o <= 1'b1;
         rx = {rx[30:0], miso_i};
         #80;
         sclk_o <= 1'b0;
      end
      #80;
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o; // Released line does not keep its last value
      #240;
   endtask
endmodule

/* verif/tb_fsp_flash_wp.sv */
`timescale 1ns/1ps
module tb_fsp_flash_wp;
   import fsp_pkg::*;
   logic        clk_i, resetn_i, arr_done_i, wp_pin, sclk, cs_n, mosi, miso, req, qe, oe_n;
   logic [15:0] nv_image, status, est;
   logic [7:0]  cmd;
   logic [20:0] addr, t;
   logic [29:0] exp_q[$];
   logic [29:0] e;
   logic [31:0] rx, seed, r;
   logic [21:0] sz, lo, hi, t22;
   logic        prot;
   int          fails, total_checks;

   fsp_flash_wp fsp_flash_wp_inst (.clk_i(clk_i), .resetn_i(resetn_i), .spi_clk_i(sclk),
      .cs_n_i(cs_n), .serial_in_pin_i(mosi), .quad_lane_two_i(wp_pin),
      .arr_done_i(arr_done_i), .nv_image_i(nv_image), .serial_out_o(miso),
      .serial_out_oe_n_o(oe_n), .arr_req_o(req), .arr_cmd_o(cmd), .arr_addr_o(addr),
      .status_o(status), .quad_lane_enable_o(qe));
   fsp_spi_host fsp_spi_host_inst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   // Clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Each request pulse takes the oldest note: {check addr, cmd, addr}
   always @(posedge clk_i) begin
      if (req === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         cmp({cmd, e[29] ? addr : e[20:0]}, e[28:0]);
      end
   end

   task automatic frm(input logic [63:0] tx, input int n);
      fsp_spi_host_inst.xfer(tx, n, rx);
   endtask

   // Let a started operation finish through the storage core
   task automatic done();
      repeat (8) @(posedge clk_i);
      if (status[SB_BUSY] === 1'b1) begin
         arr_done_i <= 1'b1;
         @(posedge clk_i);
         arr_done_i <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      cmp(exp_q.size(), 0);
      est[SB_BUSY] = 1'b0;
      cmp(status, est);
   endtask

   task automatic wrsr(input logic [15:0] v, input logic acc);
      frm({24'h0, OP_WREN}, 8);
      if (acc) exp_q.push_back({1'b0, OP_WRSR, 21'h0});
      frm({8'h0, OP_WRSR, v[7:0], v[15:8]}, 24);
      if (acc) est = {est[15], 5'h0, v[9:2], 2'b00};
      else est[SB_WEL] = 1'b1;
      done();
   endtask

   task automatic rst(input logic [15:0] img, input logic [15:0] ex);
      nv_image <= img;
      resetn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      est = ex;
      cmp(status, est);
   endtask

   task automatic rd();
      fork
         frm({48'h0, OP_RDSR1, 8'h0}, 16);
         begin
            #2000;
            cmp(oe_n, 1'b0);
         end
      join
      cmp(rx[7:0], est[7:0]);
      cmp(oe_n, 1'b1);
      frm({16'h0, OP_RDSR2, 8'h0}, 16);
      cmp(rx[7:0], est[15:8]);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #760000;
      fails++;
      finish_test();
   end

   initial begin
      resetn_i = 1'b0;
      arr_done_i = 1'b0;
      wp_pin = 1'b1;
      nv_image = 16'h8103;
      seed = 32'h7E71;
      fails = 0;
      total_checks = 0;
      rst(16'h8103, 16'h0000);
      $display("test reset finished");
      // Every level, side and granularity against one boundary sector erase
      for (int c = 0; c < 32; c++) begin
         wrsr({9'h0, c[4:3], c[2:0], 2'b00}, 1'b1);
         sz = (c[2:0] == 3'h0) ? 22'h0 : (c[2:1] == 2'b11) ? ARRAY_BYTES :
              c[4] ? (c[2] ? SEC_MAX_BYTES : SECTOR_BYTES << (c[2:0] - 1)) :
              BLOCK_BYTES << (c[2:0] - 1);
         lo = c[3] ? 22'h0 : ARRAY_BYTES - sz;
         hi = c[3] ? sz - 22'h1 : ARRAY_BYTES - 22'h1;
         r = xs();
         t22 = r[31] ? (c[3] ? sz - 22'h1 : ARRAY_BYTES - sz) :
               (c[3] ? sz : ARRAY_BYTES - sz - SECTOR_BYTES);
         t = t22[20:0] ^ {9'h0, r[11:0]};
         prot = (sz != 22'h0) && ({1'b0, t} >= lo) && ({1'b0, t} <= hi);
         frm({24'h0, OP_WREN}, 8);
         if (!prot) exp_q.push_back({1'b1, OP_SE, t & ~SE_MASK});
         frm({OP_SE, 3'h0, t}, 32);
         est[SB_WEL] = prot;
         done();
      end
      $display("test protection finished");
      wrsr(16'h0080, 1'b1);
      @(posedge clk_i);
      wp_pin <= 1'b0;
      wrsr(16'h0084, 1'b0);
      @(posedge clk_i);
      wp_pin <= 1'b1;
      wrsr(16'h0004, 1'b1);
      @(posedge clk_i);
      wp_pin <= 1'b0;
      frm({8'h0, OP_WRSR, 16'h0800}, 24);
      done();
      wrsr(16'h0200, 1'b1); // pin is driven, never tied
      cmp(qe, 1'b1);
      wrsr(16'h0280, 1'b1);
      wrsr(16'h0000, 1'b1);
      frm({24'h0, OP_WREN}, 8);
      frm({1'b0, OP_SE, 23'h0}, 31);
      est[SB_WEL] = 1'b1;
      done();
      $display("test lock finished");
      frm({24'h0, OP_WREN}, 8);
      exp_q.push_back({1'b1, OP_BE64, 21'h120000});
      frm({OP_BE64, 24'h123456}, 32);
      est[1:0] = 2'b01;
      rd();
      frm({24'h0, OP_WREN}, 8);
      exp_q.push_back({1'b0, OP_SUSP, 21'h0});
      frm({24'h0, OP_SUSP}, 8);
      est = 16'h8000;
      rd();
      exp_q.push_back({1'b0, OP_RESM, 21'h0});
      frm({24'h0, OP_RESM}, 8);
      est = 16'h0001;
      rd();
      done();
      $display("test suspend finished");
      wrsr(16'h0004, 1'b1);
      frm({56'h0, OP_WREN}, 8);
      exp_q.push_back({1'b1, OP_PP, 21'h1EFF00});
      frm({24'h0, OP_PP, 24'h1EFF12, 8'hA5}, 40);
      done();
      frm({56'h0, OP_WREN}, 8);
      frm({24'h0, OP_QPP, 24'h1F0100, 8'h5A}, 40);
      frm({56'h0, OP_CE1}, 8);
      est[SB_WEL] = 1'b1;
      done();
      frm({56'h0, OP_WRDI}, 8);
      est[SB_WEL] = 1'b0;
      done();
      frm({56'h0, OP_WREN}, 8);
      exp_q.push_back({1'b1, OP_BE32, 21'h1E8000});
      frm({32'h0, OP_BE32, 24'h1EFFFF}, 32);
      done();
      wrsr(16'h0000, 1'b1);
      frm({56'h0, OP_WREN}, 8);
      exp_q.push_back({1'b1, OP_CE2, 21'h0});
      frm({56'h0, OP_CE2}, 8);
      done();
      $display("test operations finished");
      wrsr(16'h0100, 1'b1);
      wrsr(16'h001C, 1'b0);
      rst(16'h0100, 16'h0000);
      wrsr(16'h0004, 1'b1);
      rst(16'h0180, 16'h0180);
      wrsr(16'h0000, 1'b0);
      rst(16'h0180, 16'h0180);
      $display("test power lock finished");
      finish_test();
   end
endmodule
